// ### cies_pkg.sv
// Shared constants and types for the instruction execute subset block.
package cies_pkg;
    localparam int CIES_DATA_W = 8;
    localparam int CIES_FADDR_W = 7;
    localparam int CIES_PC_W = 13;
    localparam int CIES_BUS_AW = 4;
    typedef enum logic [3:0] {
        CIES_OP_NONE,
        CIES_OP_HALT,
        CIES_OP_RET,
        CIES_OP_RRC,
        CIES_OP_LSUB,
        CIES_OP_FSUB,
        CIES_OP_SWAP,
        CIES_OP_FXOR,
        CIES_OP_LXOR
    } cies_op_type;
    typedef enum logic [1:0] {
        CIES_ST_RUN,
        CIES_ST_RET2,
        CIES_ST_SLEEP
    } cies_state_type;
    localparam logic [3:0] CIES_OFS_ACC = 4'h0;
    localparam logic [3:0] CIES_OFS_STATUS = 4'h4;
    localparam int CIES_BIT_CARRY = 0;
    localparam int CIES_BIT_HALF = 1;
    localparam int CIES_BIT_ZERO = 2;
    localparam int CIES_BIT_PD_N = 3;
    localparam int CIES_BIT_TO_N = 4;
    localparam int CIES_BIT_SLEEP = 5;
    localparam int CIES_BIT_BUSY = 6;
    localparam logic [7:0] CIES_ACC_RST = 8'h00;
    localparam logic [7:0] CIES_WDT_ZERO = 8'h00;
    localparam logic [31:0] CIES_RDATA_NONE = 32'h0000_0000;
    localparam int CIES_RET_CYCLES = 2;
endpackage : cies_pkg

// ### cies_alu.sv
// Combinational result and flag datapath of the execute subset.
`timescale 1ns/10ps
module cies_alu
    import cies_pkg::*;
(
    // Operation and operands.
    input wire cies_op_type op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] lit_i,
    input wire logic carry_i,
    // Result and flags.
    output logic [7:0] result_o,
    output logic carry_o,
    output logic half_o,
    output logic upd_carry_o,
    output logic upd_half_o,
    output logic upd_zero_o
);
    wire logic [7:0] minuend = (op_i == CIES_OP_LSUB) ? lit_i : file_i;
    // Adding the inverted subtrahend plus one gives carry out high exactly when no borrow occurs.
    wire logic [8:0] diff = {1'b0, minuend} + {1'b0, ~acc_i} + 9'h001; // [RL14]
    wire logic [4:0] low_diff = {1'b0, minuend[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01; // [RL14]
    wire logic is_sub = (op_i == CIES_OP_LSUB) || (op_i == CIES_OP_FSUB);
    wire logic is_xor = (op_i == CIES_OP_LXOR) || (op_i == CIES_OP_FXOR);
    wire logic [7:0] xor_src = (op_i == CIES_OP_LXOR) ? lit_i : file_i;
    assign result_o = is_sub ? diff[7:0] : // [RL8] [RL9]
                      is_xor ? (acc_i ^ xor_src) : // [RL11] [RL12]
                      (op_i == CIES_OP_RRC) ? {carry_i, file_i[7:1]} : // [RL6]
                      {file_i[3:0], file_i[7:4]}; // [RL10]
    assign carry_o = (op_i == CIES_OP_RRC) ? file_i[0] : diff[8]; // [RL6]
    assign half_o = low_diff[4];
    assign upd_carry_o = is_sub || (op_i == CIES_OP_RRC);
    assign upd_half_o = is_sub;
    assign upd_zero_o = is_sub || is_xor;
endmodule : cies_alu

// ### cies_exec.sv
// Execute stage for halt, return, rotate, subtract, nibble swap and XOR with an Avalon-MM register slave.
`timescale 1ns/10ps
//Function
//RL1: Halt clears the power-down status bit and sets the time-out status bit, touching no other flag.
//RL2: Halt loads the watchdog counter with zero and clears its prescaler; the code pulses wdt_load_o with zero and has no prescaler clear.
//RL3: After halt the core sleeps and executes nothing until wake-up.
//RL4: Return pops the call stack into the program counter and leaves every flag alone.
//RL5: Return takes two instruction cycles.
//RL6: Rotate right moves bit 0 into carry and old carry into bit 7, updating only carry.
//RL7: For register operands, destination 0 writes the accumulator and 1 writes the addressed register.
//RL8: Literal minus accumulator goes to the accumulator and updates carry, half carry and zero.
//RL9: Register minus accumulator goes to the chosen destination and updates carry, half carry and zero.
//RL10: Nibble swap exchanges the register halves into the destination with no flag change.
//RL11: Register XOR accumulator goes to the chosen destination and updates only zero.
//RL12: Literal XOR accumulator goes to the accumulator and updates only zero.
//RL13: Zero is set when the 8-bit result of a flag-updating operation is zero, else cleared.
//RL14: Carry and half carry are high when no borrow leaves bit 7 and bit 3 respectively.
module cies_exec
    import cies_pkg::*;
#(
    parameter int PC_W = CIES_PC_W
)(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Instruction issue.
    input wire logic issue_valid_i,
    output logic issue_ready_o,
    input wire cies_op_type opcode_i,
    input wire logic [7:0] operand_i,
    input wire logic dest_i,
    // Register file.
    input wire logic [7:0] file_rdata_i,
    output logic file_we_o,
    output logic [6:0] file_addr_o,
    output logic [7:0] file_wdata_o,
    // Call stack and program counter.
    input wire logic [PC_W-1:0] stack_top_i,
    output logic stack_pop_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_value_o,
    // Watchdog and power.
    output logic wdt_load_o,
    output logic [7:0] wdt_value_o,
    output logic sleep_o,
    input wire logic wake_i,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    cies_state_type state;
    cies_state_type next_state;
    logic [7:0] acc;
    logic carry;
    logic half;
    logic zero;
    logic pd_n;
    logic to_n;
    logic wake_meta;
    logic wake_sync;
    logic bus_ack;
    logic [PC_W-1:0] ret_target;

    wire logic take = issue_valid_i && issue_ready_o;
    wire logic [7:0] alu_result;
    wire logic alu_carry;
    wire logic alu_half;
    wire logic upd_carry;
    wire logic upd_half;
    wire logic upd_zero;

    cies_alu u_alu (
        .op_i(opcode_i),
        .acc_i(acc),
        .file_i(file_rdata_i),
        .lit_i(operand_i),
        .carry_i(carry),
        .result_o(alu_result),
        .carry_o(alu_carry),
        .half_o(alu_half),
        .upd_carry_o(upd_carry),
        .upd_half_o(upd_half),
        .upd_zero_o(upd_zero)
    );

    // Codes outside the six data operations neither write a target nor move carry, half carry or zero.
    function automatic logic cies_data_op(input cies_op_type op);
        return (op == CIES_OP_RRC) || (op == CIES_OP_LSUB) || (op == CIES_OP_FSUB) || (op == CIES_OP_SWAP)
            || (op == CIES_OP_FXOR) || (op == CIES_OP_LXOR);
    endfunction : cies_data_op

    wire logic is_data_op = cies_data_op(opcode_i);
    wire logic is_lit_op = (opcode_i == CIES_OP_LSUB) || (opcode_i == CIES_OP_LXOR);
    wire logic to_file = take && is_data_op && !is_lit_op && dest_i; // [RL7]
    wire logic to_acc = take && is_data_op && !(dest_i && !is_lit_op); // [RL7] [RL8] [RL12]
    wire logic do_halt = take && (opcode_i == CIES_OP_HALT);
    wire logic do_ret = take && (opcode_i == CIES_OP_RET);

    // Bus decode; every access answers after exactly one wait cycle.
    wire logic bus_req = avs_read_i || avs_write_i;
    wire logic bus_done = bus_req && bus_ack;
    wire logic sel_acc = avs_address_i == CIES_OFS_ACC;
    wire logic sel_status = avs_address_i == CIES_OFS_STATUS;
    wire logic bus_wr_lane = avs_write_i && bus_done && avs_byteenable_i[0];
    wire logic [7:0] status_view = {1'b0, (state == CIES_ST_RET2), (state == CIES_ST_SLEEP), to_n, pd_n, zero, half, carry};
    wire logic [31:0] next_rdata = sel_acc ? {24'h00_0000, acc} : sel_status ? {24'h00_0000, status_view} : CIES_RDATA_NONE;
    assign avs_waitrequest_o = bus_req && !bus_ack;

    // The core keeps priority: an instruction writing the same target in the same cycle beats the bus.
    wire logic [7:0] next_acc = to_acc ? alu_result : (bus_wr_lane && sel_acc) ? avs_writedata_i[7:0] : acc;
    wire logic sw_flags = bus_wr_lane && sel_status;
    wire logic next_carry = (take && upd_carry) ? alu_carry : sw_flags ? avs_writedata_i[CIES_BIT_CARRY] : carry;
    wire logic next_half = (take && upd_half) ? alu_half : sw_flags ? avs_writedata_i[CIES_BIT_HALF] : half;
    wire logic next_zero = (take && upd_zero) ? (alu_result == 8'h00) : sw_flags ? avs_writedata_i[CIES_BIT_ZERO] : zero; // [RL13]

    always_comb begin
        next_state = state;
        unique case (state)
            CIES_ST_RUN: begin
                if (do_ret) begin
                    next_state = CIES_ST_RET2; // [RL5]
                end else if (do_halt) begin
                    next_state = CIES_ST_SLEEP; // [RL3]
                end
            end
            CIES_ST_RET2: begin
                next_state = CIES_ST_RUN;
            end
            CIES_ST_SLEEP: begin
                if (wake_sync) begin
                    next_state = CIES_ST_RUN;
                end
            end
            default: begin
                next_state = CIES_ST_RUN;
            end
        endcase
    end

    // Sleeping and the second return cycle both refuse new instructions.
    assign issue_ready_o = state == CIES_ST_RUN; // [RL3] [RL5]
    assign sleep_o = state == CIES_ST_SLEEP;
    assign pc_load_o = state == CIES_ST_RET2; // [RL4]
    assign stack_pop_o = state == CIES_ST_RET2; // [RL4]
    assign pc_value_o = ret_target;

    always_ff @(posedge clk_i) begin
        wake_meta <= wake_i;
        wake_sync <= wake_meta;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= CIES_ST_RUN;
            acc <= CIES_ACC_RST;
            carry <= 1'b0;
            half <= 1'b0;
            zero <= 1'b0;
            bus_ack <= 1'b0;
            avs_readdata_o <= CIES_RDATA_NONE;
        end else begin
            state <= next_state;
            acc <= next_acc;
            carry <= next_carry;
            half <= next_half;
            zero <= next_zero;
            bus_ack <= bus_req && !bus_ack;
            avs_readdata_o <= (avs_read_i && !bus_ack) ? next_rdata : avs_readdata_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pd_n <= 1'b1;
            to_n <= 1'b1;
            wdt_load_o <= 1'b0;
            wdt_value_o <= CIES_WDT_ZERO;
            ret_target <= '0;
        end else begin
            pd_n <= do_halt ? 1'b0 : pd_n; // [RL1]
            to_n <= do_halt ? 1'b1 : to_n; // [RL1]
            wdt_load_o <= do_halt; // [RL2]
            wdt_value_o <= CIES_WDT_ZERO; // [RL2]
            ret_target <= do_ret ? stack_top_i : ret_target; // [RL4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            file_we_o <= 1'b0;
            file_addr_o <= 7'h00;
            file_wdata_o <= 8'h00;
        end else begin
            file_we_o <= to_file; // [RL7]
            file_addr_o <= to_file ? operand_i[6:0] : file_addr_o; // [RL7]
            file_wdata_o <= to_file ? alu_result : file_wdata_o; // [RL9] [RL10] [RL11]
        end
    end

    // A bus write that lands with an instruction may legally move the flags, so those cycles are left out.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_halt_flags;
        do_halt && !bus_wr_lane |=> !pd_n && to_n && $stable(carry) && $stable(half) && $stable(zero);
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flag update wrong"); // [RL1]

    property p_halt_wdt;
        do_halt |=> wdt_load_o && (wdt_value_o == CIES_WDT_ZERO) ##1 !wdt_load_o;
    endproperty
    a_halt_wdt: assert property (p_halt_wdt) else $error("watchdog not cleared by halt"); // [RL2]

    property p_sleep_hold;
        do_halt |=> sleep_o && !issue_ready_o;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("instruction accepted while asleep"); // [RL3]

    property p_ret_pc;
        do_ret && !bus_wr_lane |=> pc_load_o && stack_pop_o && (pc_value_o == $past(stack_top_i))
            && $stable(carry) && $stable(zero);
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return did not load program counter"); // [RL4]

    property p_ret_two;
        do_ret |=> !issue_ready_o ##1 issue_ready_o;
    endproperty
    a_ret_two: assert property (p_ret_two) else $error("return not two cycles"); // [RL5]

    property p_rrc;
        take && (opcode_i == CIES_OP_RRC) && !bus_wr_lane |=> (carry == $past(file_rdata_i[0]))
            && $stable(zero) && $stable(half);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate carry wrong"); // [RL6]

    property p_dest_file;
        take && (opcode_i == CIES_OP_SWAP) && dest_i && !bus_wr_lane |=> file_we_o
            && (file_addr_o == $past(operand_i[6:0]))
            && (file_wdata_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])}) && $stable(acc);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("swap to register wrong"); // [RL7] [RL10]

    property p_lsub;
        take && (opcode_i == CIES_OP_LSUB) |=> (acc == 8'($past(operand_i) - $past(acc)))
            && (carry == ($past(operand_i) >= $past(acc))) && (zero == (acc == 8'h00));
    endproperty
    a_lsub: assert property (p_lsub) else $error("literal subtract wrong"); // [RL8] [RL13] [RL14]

    property p_fsub_half;
        take && (opcode_i == CIES_OP_FSUB) |=> half == ($past(file_rdata_i[3:0]) >= $past(acc[3:0]));
    endproperty
    a_fsub_half: assert property (p_fsub_half) else $error("half carry wrong"); // [RL9] [RL14]

    property p_lxor;
        take && (opcode_i == CIES_OP_LXOR) && !bus_wr_lane |=> (acc == ($past(acc) ^ $past(operand_i)))
            && $stable(carry) && (zero == (acc == 8'h00));
    endproperty
    a_lxor: assert property (p_lxor) else $error("literal xor wrong"); // [RL12] [RL13]

    property p_fxor_acc;
        take && (opcode_i == CIES_OP_FXOR) && !dest_i |=> (acc == ($past(acc) ^ $past(file_rdata_i))) && !file_we_o;
    endproperty
    a_fxor_acc: assert property (p_fxor_acc) else $error("register xor wrong"); // [RL11]

    property p_fsub_file;
        take && (opcode_i == CIES_OP_FSUB) && dest_i && !bus_wr_lane |=> file_we_o && $stable(acc)
            && (file_wdata_o == 8'($past(file_rdata_i) - $past(acc)))
            && (carry == ($past(file_rdata_i) >= $past(acc)))
            && (zero == (file_wdata_o == 8'h00));
    endproperty
    a_fsub_file: assert property (p_fsub_file) else $error("register subtract wrong"); // [RL7] [RL9] [RL13] [RL14]

    property p_fxor_file;
        take && (opcode_i == CIES_OP_FXOR) && dest_i && !bus_wr_lane |=> file_we_o && $stable(acc)
            && (file_wdata_o == ($past(acc) ^ $past(file_rdata_i))) && (zero == (file_wdata_o == 8'h00))
            && $stable(carry) && $stable(half);
    endproperty
    a_fxor_file: assert property (p_fxor_file) else $error("register xor to register wrong"); // [RL7] [RL11] [RL13]

    property p_rrc_acc;
        take && (opcode_i == CIES_OP_RRC) && !dest_i |=> acc == {$past(carry), $past(file_rdata_i[7:1])};
    endproperty
    a_rrc_acc: assert property (p_rrc_acc) else $error("rotate result wrong"); // [RL6] [RL7]

    property p_swap_acc;
        take && (opcode_i == CIES_OP_SWAP) && !dest_i && !bus_wr_lane |=> !file_we_o && $stable(carry)
            && $stable(half) && $stable(zero) && (acc == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])});
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap to accumulator wrong"); // [RL7] [RL10]

    property p_no_effect;
        take && !cies_data_op(opcode_i) && !bus_wr_lane |=> $stable(acc) && !file_we_o
            && $stable(carry) && $stable(half) && $stable(zero);
    endproperty
    a_no_effect: assert property (p_no_effect) else $error("control instruction touched data"); // [RL1] [RL4]

    property p_bus_wait;
        bus_req && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus wait longer than one cycle");

    c_ret: cover property (do_ret ##2 issue_ready_o);
    c_sleep_wake: cover property (do_halt ##[1:20] (state == CIES_ST_SLEEP) && wake_sync);
    c_sub_zero: cover property (take && (opcode_i == CIES_OP_FSUB) ##1 zero);
    c_bus_read: cover property (avs_read_i && !avs_waitrequest_o && sel_status);
    c_file_write: cover property (file_we_o ##1 issue_ready_o);
endmodule : cies_exec

// ### cies_partner.sv
// Behavioural register file and call stack on the far side of the execute block.
`timescale 1ns/10ps
module cies_partner #(
    parameter logic [12:0] RET_ADDR = 13'h0ABC
)(
    // Clock.
    input wire logic clk_i,
    // Register file.
    input wire logic [6:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire logic we_i,
    input wire logic [6:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Call stack.
    input wire logic pop_i,
    output logic [12:0] top_o
);
    logic [7:0] mem [128];
    // Reads are combinational because the execute stage uses the value in the same cycle.
    assign rdata_o = mem[raddr_i];
    initial top_o = RET_ADDR;
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        // A popped entry is gone, so its inverse is shown rather than a stale copy.
        if (pop_i) begin
            top_o <= ~top_o;
        end
    end
endmodule : cies_partner

// ### tb.sv
// Self-checking testbench for the execute subset block.
`timescale 1ns/10ps
module tb;
    import cies_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic issue_valid_i = 1'b0;
    cies_op_type opcode_i = CIES_OP_NONE;
    logic [7:0] operand_i = 8'h00;
    logic dest_i = 1'b0;
    logic wake_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'h1;
    logic issue_ready_o, file_we_o, stack_pop_o, pc_load_o, wdt_load_o, sleep_o, avs_waitrequest_o;
    logic [6:0] file_addr_o;
    logic [7:0] file_wdata_o, file_rdata_i, wdt_value_o;
    logic [12:0] stack_top_i, pc_value_o, cap_pc;
    logic [31:0] avs_readdata_o, rd, cap_file, cap_ctl;
    int mismatches = 0;
    int checks_done = 0;
    localparam logic [7:0] SA [3] = '{8'h05, 8'h10, 8'h0F};
    localparam logic [7:0] SK [3] = '{8'h03, 8'h10, 8'h30};

    cies_exec #(.PC_W(13)) i_cies_exec (.clk_i(clk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i),
        .issue_ready_o(issue_ready_o), .opcode_i(opcode_i), .operand_i(operand_i), .dest_i(dest_i),
        .file_rdata_i(file_rdata_i), .file_we_o(file_we_o), .file_addr_o(file_addr_o),
        .file_wdata_o(file_wdata_o), .stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o),
        .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .wdt_load_o(wdt_load_o), .wdt_value_o(wdt_value_o),
        .sleep_o(sleep_o), .wake_i(wake_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
    cies_partner #(.RET_ADDR(13'h0ABC)) i_cies_partner (.clk_i(clk_i), .raddr_i(operand_i[6:0]),
        .rdata_o(file_rdata_i), .we_i(file_we_o), .waddr_i(file_addr_o), .wdata_i(file_wdata_o),
        .pop_i(stack_pop_o), .top_o(stack_top_i));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Waits are bounded so a stuck handshake ends the run instead of hanging it.
    task automatic wait_lo(ref logic sig, input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (sig !== lvl && n < 50);
        if (sig !== lvl) begin
            chk(32'h0000_0000, 32'h0000_0001);
            end_of_test();
        end
    endtask : wait_lo

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        wait_lo(avs_waitrequest_o, 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdc

    task automatic issue(input cies_op_type op, input logic [7:0] opd, input logic d);
        @(posedge clk_i);
        opcode_i <= op;
        operand_i <= opd;
        dest_i <= d;
        issue_valid_i <= 1'b1;
        wait_lo(issue_ready_o, 1'b1);
        issue_valid_i <= 1'b0;
        @(negedge clk_i);
        cap_file = {16'h0000, file_we_o, file_addr_o, file_wdata_o};
        cap_ctl = {27'h0, issue_ready_o, sleep_o, wdt_load_o, pc_load_o, stack_pop_o};
        cap_pc = pc_value_o;
    endtask : issue

    function automatic logic [31:0] sub_st(input logic [7:0] k, input logic [7:0] w);
        logic [7:0] r;
        r = k - w;
        return {27'h0, 2'b11, r == 8'h00, k[3:0] >= w[3:0], k >= w};
    endfunction : sub_st

    initial begin
        repeat (20000) @(posedge clk_i);
        chk(32'h0000_0000, 32'h0000_0001);
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdc(CIES_OFS_STATUS, 32'h0000_0018);
        rdc(CIES_OFS_ACC, 32'h0000_0000);
        rdc(4'h8, 32'h0000_0000);
        // A write with lane 0 disabled must leave the accumulator alone.
        avs_byteenable_i <= 4'h0;
        bus(1'b1, CIES_OFS_ACC, 32'h0000_00FF);
        avs_byteenable_i <= 4'h1;
        rdc(CIES_OFS_ACC, 32'h0000_0000);
        $display("test reset done");
        // The destination bit is set on purpose: literal forms must still go to the accumulator.
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, CIES_OFS_ACC, {24'h0, SA[i]});
            issue(CIES_OP_LSUB, SK[i], 1'b1);
            rdc(CIES_OFS_ACC, {24'h0, SK[i] - SA[i]});
            rdc(CIES_OFS_STATUS, sub_st(SK[i], SA[i]));
        end
        $display("test literal subtract done");
        i_cies_partner.mem[127] = 8'h20;
        i_cies_partner.mem[3] = 8'h44;
        bus(1'b1, CIES_OFS_ACC, 32'h0000_0021);
        issue(CIES_OP_FSUB, 8'h7F, 1'b1);
        chk(cap_file, 32'h0000_FFFF);
        rdc(CIES_OFS_ACC, 32'h0000_0021);
        rdc(CIES_OFS_STATUS, sub_st(8'h20, 8'h21));
        bus(1'b1, CIES_OFS_ACC, 32'h0000_0044);
        issue(CIES_OP_FSUB, 8'h03, 1'b0);
        chk(cap_file[15], 1'b0);
        rdc(CIES_OFS_ACC, 32'h0000_0000);
        rdc(CIES_OFS_STATUS, 32'h0000_001F);
        $display("test register subtract done");
        i_cies_partner.mem[5] = 8'hA3;
        bus(1'b1, CIES_OFS_STATUS, 32'h0000_0007);
        issue(CIES_OP_SWAP, 8'h05, 1'b0);
        rdc(CIES_OFS_ACC, 32'h0000_003A);
        rdc(CIES_OFS_STATUS, 32'h0000_001F);
        i_cies_partner.mem[9] = 8'h02;
        issue(CIES_OP_RRC, 8'h09, 1'b1);
        chk(cap_file, 32'h0000_8981);
        rdc(CIES_OFS_STATUS, 32'h0000_001E);
        issue(CIES_OP_RRC, 8'h09, 1'b0);
        rdc(CIES_OFS_ACC, 32'h0000_0040);
        rdc(CIES_OFS_STATUS, 32'h0000_001F);
        $display("test swap and rotate done");
        i_cies_partner.mem[10] = 8'h5A;
        bus(1'b1, CIES_OFS_ACC, 32'h0000_005A);
        bus(1'b1, CIES_OFS_STATUS, 32'h0000_0003);
        issue(CIES_OP_FXOR, 8'h0A, 1'b1);
        chk(cap_file, 32'h0000_8A00);
        rdc(CIES_OFS_STATUS, 32'h0000_001F);
        issue(CIES_OP_LXOR, 8'hA5, 1'b0);
        rdc(CIES_OFS_ACC, 32'h0000_00FF);
        rdc(CIES_OFS_STATUS, 32'h0000_001B);
        $display("test xor done");
        issue(CIES_OP_RET, 8'h00, 1'b0);
        chk(cap_ctl, 32'h0000_0003);
        chk(cap_pc, 13'h0ABC);
        rdc(CIES_OFS_STATUS, 32'h0000_001B);
        $display("test return done");
        issue(CIES_OP_HALT, 8'h00, 1'b0);
        chk(cap_ctl, 32'h0000_000C);
        chk(wdt_value_o, 8'h00);
        rdc(CIES_OFS_STATUS, 32'h0000_0033);
        // An instruction offered while asleep stays offered and must not run before wake-up.
        @(posedge clk_i);
        opcode_i <= CIES_OP_LXOR;
        operand_i <= 8'h0F;
        dest_i <= 1'b0;
        issue_valid_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdc(CIES_OFS_ACC, 32'h0000_00FF);
        @(posedge clk_i);
        wake_i <= 1'b1;
        wait_lo(issue_ready_o, 1'b1);
        issue_valid_i <= 1'b0;
        wake_i <= 1'b0;
        @(negedge clk_i);
        chk(sleep_o, 1'b0);
        rdc(CIES_OFS_ACC, 32'h0000_00F0);
        $display("test halt and wake done");
        end_of_test();
    end
endmodule : tb
